// ---- hw/srxc_top.sv ----
// Purpose: Control bank and sample handling for the receiver and rate converter.
// Assumes: Receiver flags and samples arrive from logic on clk_i; register
//          port is the byte-wide control interface after its serial decoder.
// Notes: De-emphasis filtering and clock muxing live elsewhere; this block
//        drives their selects.
// Behaviour
// - The converter mute bit fades the converter output to silence.
// - The 7-bit delay field delays the converter path by 0 to 127 samples.
// - Without lock the receiver runs from the recovered clock, or internal clock one if chosen.
// - The ratio field picks a 128, 256 or 512 times fs clock; code 11 is reserved.
// - Auto de-emphasis follows the received channel status.
// - A parity or biphase error passes, holds the last good sample or sends zero.
// - Lock loss passes, holds, sends zero or fades the last good sample.
// - The hard mute bit silences receiver audio.
// - The PLL reference is the preamble clock, or a serial port clock when chosen.
// - The port select picks playback, auxiliary in, record or auxiliary out.
// - Non-audio blocking keeps non-audio data out of the converter.
// - Compressed payloads are always kept out of the converter.
// - Validity blocking keeps invalid data out of the converter.
// - A cleared blocking bit lets that kind of data through.
`timescale 1ns/1ps
`default_nettype none
module srxc_top (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvld_o,
   input wire logic pll_locked_i,
   input wire logic [srxc_pkg::SRXC_SAMPLE_W-1:0] rx_sample_i,
   input wire logic rx_vld_i,
   input wire logic rx_parity_err_i,
   input wire logic rx_biphase_err_i,
   input wire logic rx_validity_i,
   input wire logic rx_nonaudio_i,
   input wire logic rx_compressed_i,
   input wire logic rx_cs_emphasis_i,
   output logic [srxc_pkg::SRXC_SAMPLE_W-1:0] rx_audio_o,
   output logic rx_audio_vld_o,
   output logic [srxc_pkg::SRXC_SAMPLE_W-1:0] src_in_sample_o,
   output logic src_in_vld_o,
   input wire logic [srxc_pkg::SRXC_SAMPLE_W-1:0] src_out_sample_i,
   input wire logic src_out_vld_i,
   output logic [srxc_pkg::SRXC_SAMPLE_W-1:0] src_out_sample_o,
   output logic src_out_vld_o,
   output logic rx_clk_internal_one_o,
   output logic [1:0] recovered_clock_ratio_o,
   output logic deemphasis_active_o,
   output logic pll_ref_from_port_o,
   output logic [1:0] pll_ref_port_select_o
);
   import srxc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] src_delay_and_mute;
      logic [7:0] receiver_config_first;
      logic [7:0] receiver_config_second;
      logic [7:0] rdata;
      logic rvld;
      logic [SRXC_SAMPLE_W-1:0] last_good;
      logic [SRXC_SAMPLE_W-1:0] stage;
      logic stage_vld;
      logic stage_blocked;
      logic [SRXC_SAMPLE_W-1:0] rx_audio;
      logic rx_audio_vld;
      logic [SRXC_SAMPLE_W-1:0] src_in;
      logic src_in_vld;
      logic [SRXC_SAMPLE_W-1:0] src_out;
      logic src_out_vld;
      logic clk_int_one;
      logic deemph;
   } srxc_top_s;

   srxc_top_s st;
   srxc_top_s next_st;

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   logic soft_mute_en;
   logic [SRXC_DELAY_W-1:0] fir_delay_samples;
   logic unlocked_clock_select;
   logic auto_deemphasis_en;
   srxc_err_e err_mode;
   srxc_lock_e lock_mode;
   logic receiver_hard_mute;
   logic block_nonaudio_data;
   logic block_invalid_data;
   logic rx_err;

   assign soft_mute_en = st.src_delay_and_mute[SRXC_POS_SOFT_MUTE];
   assign fir_delay_samples = st.src_delay_and_mute[SRXC_POS_DELAY_LSB +: SRXC_DELAY_W];
   assign unlocked_clock_select = st.receiver_config_first[SRXC_POS_UNLOCKED_CLK];
   assign auto_deemphasis_en = st.receiver_config_first[SRXC_POS_AUTO_DEEMPHASIS_EN];
   assign err_mode = srxc_err_e'(st.receiver_config_first[SRXC_POS_ERR_LSB +: 2]);
   assign lock_mode = srxc_lock_e'(st.receiver_config_first[SRXC_POS_LOCK_LSB +: 2]);
   assign receiver_hard_mute = st.receiver_config_second[SRXC_POS_HARD_MUTE];
   assign block_nonaudio_data = st.receiver_config_second[SRXC_POS_BLOCK_NONAUDIO];
   assign block_invalid_data = st.receiver_config_second[SRXC_POS_BLOCK_INVALID];
   assign rx_err = rx_parity_err_i | rx_biphase_err_i;

   // ----------------------------------------------------------------
   // Ramp and delay helpers
   // ----------------------------------------------------------------
   logic [SRXC_SAMPLE_W-1:0] rx_ramp_sample;
   logic rx_ramp_vld;
   logic rx_ramp_mute;
   logic [SRXC_SAMPLE_W-1:0] dl_sample;
   logic dl_vld;
   logic [SRXC_SAMPLE_W-1:0] cv_ramp_sample;
   logic cv_ramp_vld;

   assign rx_ramp_mute = !pll_locked_i && (lock_mode == SRXC_LOCK_RAMP);

   srxc_soft_mute u_rx_ramp (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .mute_i(rx_ramp_mute),
      .sample_i(st.stage),
      .vld_i(st.stage_vld),
      .sample_o(rx_ramp_sample),
      .vld_o(rx_ramp_vld),
      .muted_o()
   );

   srxc_delay_line u_delay (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .delay_i(fir_delay_samples),
      .sample_i(src_out_sample_i),
      .vld_i(src_out_vld_i),
      .sample_o(dl_sample),
      .vld_o(dl_vld)
   );

   srxc_soft_mute u_cv_ramp (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .mute_i(soft_mute_en),
      .sample_i(dl_sample),
      .vld_i(dl_vld),
      .sample_o(cv_ramp_sample),
      .vld_o(cv_ramp_vld),
      .muted_o()
   );

   // The blocking flag rides beside the sample through the ramp stage.
   logic blocked_d;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.rvld = 1'b0;
      next_st.stage_vld = 1'b0;
      next_st.rx_audio_vld = 1'b0;
      next_st.src_in_vld = 1'b0;
      next_st.src_out_vld = 1'b0;

      if (reg_wr_i) begin
         case (reg_addr_i)
            SRXC_ADDR_SRC_DELAY_AND_MUTE: next_st.src_delay_and_mute = reg_wdata_i;
            SRXC_ADDR_RECEIVER_CONFIG_FIRST: next_st.receiver_config_first = reg_wdata_i;
            SRXC_ADDR_RECEIVER_CONFIG_SECOND: begin
               next_st.receiver_config_second = reg_wdata_i & SRXC_CFG2_MASK;
            end
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         next_st.rvld = 1'b1;
         case (reg_addr_i)
            SRXC_ADDR_SRC_DELAY_AND_MUTE: next_st.rdata = st.src_delay_and_mute;
            SRXC_ADDR_RECEIVER_CONFIG_FIRST: next_st.rdata = st.receiver_config_first;
            SRXC_ADDR_RECEIVER_CONFIG_SECOND: next_st.rdata = st.receiver_config_second;
            default: next_st.rdata = 8'h00;
         endcase
      end

      next_st.clk_int_one = !pll_locked_i && unlocked_clock_select;
      next_st.deemph = auto_deemphasis_en && rx_cs_emphasis_i;

      if (rx_vld_i) begin
         next_st.stage_vld = 1'b1;
         next_st.stage = rx_sample_i;
         if (!pll_locked_i) begin
            case (lock_mode)
               SRXC_LOCK_HOLD: next_st.stage = st.last_good;
               SRXC_LOCK_ZERO: next_st.stage = '0;
               SRXC_LOCK_RAMP: next_st.stage = st.last_good;
               default: next_st.stage = rx_sample_i;
            endcase
         end else if (rx_err) begin
            case (err_mode)
               SRXC_ERR_HOLD: next_st.stage = st.last_good;
               SRXC_ERR_ZERO: next_st.stage = '0;
               default: next_st.stage = rx_sample_i;
            endcase
         end else begin
            next_st.last_good = rx_sample_i;
         end
         next_st.stage_blocked = rx_compressed_i ||
                                 (block_nonaudio_data && rx_nonaudio_i) ||
                                 (block_invalid_data && rx_validity_i);
      end

      if (rx_ramp_vld) begin
         next_st.rx_audio = receiver_hard_mute ? '0 : rx_ramp_sample;
         next_st.rx_audio_vld = 1'b1;
         next_st.src_in = receiver_hard_mute ? '0 : rx_ramp_sample;
         next_st.src_in_vld = !blocked_d;
      end

      if (cv_ramp_vld) begin
         next_st.src_out = cv_ramp_sample;
         next_st.src_out_vld = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
         st.src_delay_and_mute <= SRXC_RST_SRC_DELAY_AND_MUTE;
         st.receiver_config_first <= SRXC_RST_RECEIVER_CONFIG_FIRST;
         st.receiver_config_second <= SRXC_RST_RECEIVER_CONFIG_SECOND;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // The ramp stage has one cycle of latency, matched here.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         blocked_d <= 1'b0;
      end else if (ce_i && st.stage_vld) begin
         blocked_d <= st.stage_blocked;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o = st.rdata;
   assign reg_rvld_o = st.rvld;
   assign rx_audio_o = st.rx_audio;
   assign rx_audio_vld_o = st.rx_audio_vld;
   assign src_in_sample_o = st.src_in;
   assign src_in_vld_o = st.src_in_vld;
   assign src_out_sample_o = st.src_out;
   assign src_out_vld_o = st.src_out_vld;
   assign rx_clk_internal_one_o = st.clk_int_one;
   assign deemphasis_active_o = st.deemph;
   assign recovered_clock_ratio_o = st.receiver_config_first[SRXC_POS_RATIO_LSB +: 2];
   assign pll_ref_from_port_o = st.receiver_config_second[SRXC_POS_REF_FROM_PORT];
   assign pll_ref_port_select_o = st.receiver_config_second[SRXC_POS_REF_SEL_LSB +: 2];
endmodule // srxc_top
`default_nettype wire

// ---- common/srxc_pkg.sv ----
// Purpose: Shared constants for the receiver and rate converter control bank.
// Assumes: 8-bit control registers on a 7-bit register address.
// Notes: Reset values are all zero, which leaves every feature off.
`default_nettype none
package srxc_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [6:0] SRXC_ADDR_SRC_DELAY_AND_MUTE = 7'h08;
   localparam logic [6:0] SRXC_ADDR_RECEIVER_CONFIG_FIRST = 7'h09;
   localparam logic [6:0] SRXC_ADDR_RECEIVER_CONFIG_SECOND = 7'h0a;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SRXC_RST_SRC_DELAY_AND_MUTE = 8'h00;
   localparam logic [7:0] SRXC_RST_RECEIVER_CONFIG_FIRST = 8'h00;
   localparam logic [7:0] SRXC_RST_RECEIVER_CONFIG_SECOND = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SRXC_POS_SOFT_MUTE = 7;
   localparam int SRXC_POS_DELAY_LSB = 0;
   localparam int SRXC_POS_UNLOCKED_CLK = 7;
   localparam int SRXC_POS_RATIO_LSB = 5;
   localparam int SRXC_POS_AUTO_DEEMPHASIS_EN = 4;
   localparam int SRXC_POS_ERR_LSB = 2;
   localparam int SRXC_POS_LOCK_LSB = 0;
   localparam int SRXC_POS_HARD_MUTE = 7;
   localparam int SRXC_POS_REF_FROM_PORT = 6;
   localparam int SRXC_POS_REF_SEL_LSB = 4;
   localparam int SRXC_POS_BLOCK_NONAUDIO = 1;
   localparam int SRXC_POS_BLOCK_INVALID = 0;
   // Bits that exist in the second receiver register; bits 3:2 read zero.
   localparam logic [7:0] SRXC_CFG2_MASK = 8'hf3;

   // ----------------------------------------------------------------
   // Data path sizes and ramp timing
   // ----------------------------------------------------------------
   localparam int SRXC_SAMPLE_W = 24;
   localparam int SRXC_DELAY_W = 7;
   localparam int SRXC_DELAY_DEPTH = 128;
   localparam int SRXC_GAIN_W = 9;
   localparam logic [8:0] SRXC_GAIN_UNITY = 9'h100;
   localparam logic [8:0] SRXC_GAIN_STEP = 9'h008;

   // ----------------------------------------------------------------
   // Mode codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRXC_ERR_NONE = 2'h0,
      SRXC_ERR_HOLD = 2'h1,
      SRXC_ERR_ZERO = 2'h2,
      SRXC_ERR_RSVD = 2'h3
   } srxc_err_e;

   typedef enum logic [1:0] {
      SRXC_LOCK_NONE = 2'h0,
      SRXC_LOCK_HOLD = 2'h1,
      SRXC_LOCK_ZERO = 2'h2,
      SRXC_LOCK_RAMP = 2'h3
   } srxc_lock_e;
endpackage
`default_nettype wire

// ---- hw/srxc_delay_line.sv ----
// Purpose: Programmable delay of 0 to 127 input samples on the converter path.
// Assumes: One sample per valid strobe; delay changes take effect at once.
// Notes: Unwritten entries read as unknown until filled.
`timescale 1ns/1ps
`default_nettype none
module srxc_delay_line (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [srxc_pkg::SRXC_DELAY_W-1:0] delay_i,
   input wire logic [srxc_pkg::SRXC_SAMPLE_W-1:0] sample_i,
   input wire logic vld_i,
   output logic [srxc_pkg::SRXC_SAMPLE_W-1:0] sample_o,
   output logic vld_o
);
   import srxc_pkg::*;

   typedef struct packed {
      logic [SRXC_DELAY_W-1:0] wptr;
      logic [SRXC_SAMPLE_W-1:0] out;
      logic vld;
   } srxc_dl_s;

   srxc_dl_s st;
   srxc_dl_s next_st;
   logic [SRXC_SAMPLE_W-1:0] mem [SRXC_DELAY_DEPTH];
   logic [SRXC_DELAY_W-1:0] rptr;

   assign rptr = st.wptr - delay_i;

   always_comb begin
      next_st = st;
      next_st.vld = 1'b0;
      if (vld_i) begin
         next_st.wptr = st.wptr + 7'h01;
         next_st.vld = 1'b1;
         next_st.out = (delay_i == 7'h00) ? sample_i : mem[rptr];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // Storage has no reset so it can map onto a RAM; it is cleared by use.
   always_ff @(posedge clk_i) begin
      if (ce_i && vld_i) begin
         mem[st.wptr] <= sample_i;
      end
   end

   assign sample_o = st.out;
   assign vld_o = st.vld;
endmodule // srxc_delay_line
`default_nettype wire

// ---- hw/srxc_soft_mute.sv ----
// Purpose: Gain ramp that fades samples to zero and back.
// Assumes: Signed two's complement samples, one per valid strobe.
// Notes: The gain moves one step per sample, so a full ramp takes 32 samples.
`timescale 1ns/1ps
`default_nettype none
module srxc_soft_mute (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic mute_i,
   input wire logic [srxc_pkg::SRXC_SAMPLE_W-1:0] sample_i,
   input wire logic vld_i,
   output logic [srxc_pkg::SRXC_SAMPLE_W-1:0] sample_o,
   output logic vld_o,
   output logic muted_o
);
   import srxc_pkg::*;

   typedef struct packed {
      logic [SRXC_GAIN_W-1:0] gain;
      logic [SRXC_SAMPLE_W-1:0] out;
      logic vld;
   } srxc_sm_s;

   srxc_sm_s st;
   srxc_sm_s next_st;
   logic signed [SRXC_SAMPLE_W+SRXC_GAIN_W:0] prod;

   assign prod = $signed(sample_i) * $signed({1'b0, st.gain});

   always_comb begin
      next_st = st;
      next_st.vld = 1'b0;
      if (vld_i) begin
         if (mute_i) begin
            next_st.gain = (st.gain > SRXC_GAIN_STEP) ? st.gain - SRXC_GAIN_STEP : 9'h000;
         end else begin
            next_st.gain = (st.gain < SRXC_GAIN_UNITY - SRXC_GAIN_STEP) ?
                           st.gain + SRXC_GAIN_STEP : SRXC_GAIN_UNITY;
         end
         next_st.out = prod[SRXC_SAMPLE_W+7:8];
         next_st.vld = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '{gain: SRXC_GAIN_UNITY, out: '0, vld: 1'b0};
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign sample_o = st.out;
   assign vld_o = st.vld;
   assign muted_o = (st.gain == 9'h000);
endmodule // srxc_soft_mute
`default_nettype wire

// ---- tb/srxc_src_model.sv ----
// Purpose: Source of receiver samples and their flags.
// Assumes: Samples are sent one at a time by the bench through send.
// Notes: Idle lines show inverted data so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module srxc_src_model (
   input wire logic clk_i,
   output logic [srxc_pkg::SRXC_SAMPLE_W-1:0] sample_o,
   output logic vld_o,
   output logic [4:0] flags_o
);
   import srxc_pkg::*;
   // ---------------------------------------------------------------
   // Sample delivery
   // ---------------------------------------------------------------
   initial begin
      vld_o = 1'b0;
      sample_o = '0;
      flags_o = '0;
   end
   // Flags are {compressed, nonaudio, invalid, biphase, parity}.
   task automatic send(input logic [23:0] s, input logic [4:0] f, input int gap);
      repeat (gap) @(negedge clk_i);
      @(negedge clk_i);
      sample_o = s;
      flags_o = f;
      vld_o = 1'b1;
      @(negedge clk_i);
      vld_o = 1'b0;
      sample_o = ~s;
      flags_o = ~f;
   endtask
endmodule // srxc_src_model
`default_nettype wire

// ---- tb/srxc_top_asserts.sv ----
// Purpose: Port-level checks for the control bank.
// Assumes: One clock; shadows copy host writes to the receiver registers.
// Notes: Gating checks expect settings to stay still while samples fly.
`timescale 1ns/1ps
`default_nettype none
module srxc_top_asserts (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvld_o,
   input wire logic pll_locked_i,
   input wire logic rx_vld_i,
   input wire logic rx_validity_i,
   input wire logic rx_nonaudio_i,
   input wire logic rx_compressed_i,
   input wire logic rx_cs_emphasis_i,
   input wire logic [srxc_pkg::SRXC_SAMPLE_W-1:0] rx_audio_o,
   input wire logic rx_audio_vld_o,
   input wire logic src_in_vld_o,
   input wire logic src_out_vld_i,
   input wire logic src_out_vld_o,
   input wire logic rx_clk_internal_one_o,
   input wire logic deemphasis_active_o,
   input wire logic pll_ref_from_port_o,
   input wire logic [1:0] pll_ref_port_select_o
);
   import srxc_pkg::*;
   // ---------------------------------------------------------------
   // Shadow copies
   // ---------------------------------------------------------------
   logic [7:0] sh1;
   logic [7:0] sh2;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sh1 <= '0;
         sh2 <= '0;
      end else if (reg_wr_i && ce_i) begin
         if (reg_addr_i == 7'h09) sh1 <= reg_wdata_i;
         if (reg_addr_i == 7'h0a) sh2 <= reg_wdata_i;
      end
   end
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   rd_answer_a: assert property (reg_rd_i && ce_i |=> reg_rvld_o)
      else $error("read answer missing");
   rvld_cause_a: assert property (reg_rvld_o && $past(ce_i) |-> $past(reg_rd_i))
      else $error("read answer without read");
   unmapped_zero_a: assert property (reg_rd_i && ce_i && (reg_addr_i < 7'h08
      || reg_addr_i > 7'h0a) |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   rx_latency_a: assert property (rx_vld_i ##0 ce_i [*4] |-> rx_audio_vld_o)
      else $error("receiver output late");
   src_latency_a: assert property (src_out_vld_i ##0 ce_i [*4] |-> src_out_vld_o)
      else $error("converter output late");
   compressed_block_a: assert property (rx_vld_i && rx_compressed_i |-> ##3 !src_in_vld_o)
      else $error("compressed data reached converter");
   nonaudio_block_a: assert property (rx_vld_i && rx_nonaudio_i && sh2[1] |-> ##3 !src_in_vld_o)
      else $error("nonaudio data reached converter");
   valid_block_a: assert property (rx_vld_i && rx_validity_i && sh2[0] |-> ##3 !src_in_vld_o)
      else $error("invalid data reached converter");
   gate_pass_a: assert property (rx_vld_i && !rx_compressed_i && !(rx_nonaudio_i && sh2[1])
      && !(rx_validity_i && sh2[0]) ##0 ce_i [*4] |-> src_in_vld_o)
      else $error("allowed data kept from converter");
   hard_mute_a: assert property (rx_audio_vld_o && sh2[7] && $past(sh2[7]) |-> rx_audio_o == '0)
      else $error("hard mute let audio through");
   clk_select_a: assert property ($stable({pll_locked_i, sh1[7]}) [*2] |->
      rx_clk_internal_one_o == (!pll_locked_i && sh1[7])) else $error("receiver clock select wrong");
   ref_select_a: assert property ($stable(sh2[6:4]) [*2] |->
      {pll_ref_from_port_o, pll_ref_port_select_o} == sh2[6:4]) else $error("reference select wrong");
   deemph_a: assert property ($stable({rx_cs_emphasis_i, sh1[4]}) [*2] |->
      deemphasis_active_o == (rx_cs_emphasis_i && sh1[4])) else $error("de-emphasis state wrong");
   cover property (rx_audio_vld_o && sh2[7]);
   cover property (rx_vld_i && rx_compressed_i);
   cover property (rx_clk_internal_one_o);
endmodule // srxc_top_asserts
bind srxc_top srxc_top_asserts u_srxc_top_asserts (.*);
`default_nettype wire

// ---- tb/srxc_top_tb.sv ----
// Purpose: Self-checking bench for the control bank.
// Assumes: Clock enable stays high; the source model feeds the receiver.
// Notes: Expected values come from reset constants, written fields and sent samples.
`timescale 1ns/1ps
`default_nettype none
module srxc_top_tb;
   import srxc_pkg::*;
   typedef logic [SRXC_SAMPLE_W-1:0] srxc_smp_t;
   logic clk_i = 0, arst_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, pll_locked_i = 1;
   logic [6:0] reg_addr_i = '0;
   logic [7:0] reg_wdata_i = '0, reg_rdata_o;
   logic reg_rvld_o, rx_vld_i, rx_parity_err_i, rx_biphase_err_i, rx_validity_i;
   logic rx_nonaudio_i, rx_compressed_i, rx_cs_emphasis_i = 0, src_out_vld_i = 0;
   srxc_smp_t rx_sample_i, rx_audio_o, src_in_sample_o, src_out_sample_o, last_rx, last_in, e;
   srxc_smp_t src_out_sample_i = '0;
   logic rx_audio_vld_o, src_in_vld_o, src_out_vld_o, rx_clk_internal_one_o;
   logic deemphasis_active_o, pll_ref_from_port_o;
   logic [1:0] recovered_clock_ratio_o, pll_ref_port_select_o;
   int failures = 0, comparisons = 0, n_in = 0, n0;
   srxc_smp_t outq[$];
   logic [7:0] gate[6] = '{8'h88, 8'h84, 8'h48, 8'h24, 8'h10, 8'he0};
   logic [7:0] dly[3] = '{8'h00, 8'h03, 8'h7f};
   srxc_top u_srxc_top (.*);
   srxc_src_model u_srxc_src_model (.clk_i(clk_i), .sample_o(rx_sample_i), .vld_o(rx_vld_i),
      .flags_o({rx_compressed_i, rx_nonaudio_i, rx_validity_i, rx_biphase_err_i, rx_parity_err_i}));
   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (rx_audio_vld_o === 1'b1) last_rx <= rx_audio_o;
      if (src_in_vld_o === 1'b1) n_in <= n_in + 1;
      if (src_in_vld_o === 1'b1) last_in <= src_in_sample_o;
      if (src_out_vld_o === 1'b1) outq.push_back(src_out_sample_o);
   end
   // ---------------------------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1;
      @(negedge clk_i);
      reg_wr_i = 0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_rd_i = 1;
      @(negedge clk_i);
      reg_rd_i = 0;
      chk("rvld", 1, reg_rvld_o);
      chk("rdata", x, reg_rdata_o);
   endtask
   task automatic rx(input srxc_smp_t s, input logic [4:0] f, input int gap);
      u_srxc_src_model.send(s, f, gap);
      repeat (6) @(negedge clk_i);
   endtask
   task automatic sout(input srxc_smp_t s, input int gap);
      repeat (gap) @(negedge clk_i);
      @(negedge clk_i);
      src_out_sample_i = s;
      src_out_vld_i = 1;
      @(negedge clk_i);
      src_out_vld_i = 0;
      src_out_sample_i = ~s;
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      #100us;
      failures++;
      final_report();
   end
   initial begin
      repeat (20) @(negedge clk_i);
      arst_n_i = 1;
      rd(SRXC_ADDR_SRC_DELAY_AND_MUTE, SRXC_RST_SRC_DELAY_AND_MUTE);
      rd(SRXC_ADDR_RECEIVER_CONFIG_FIRST, SRXC_RST_RECEIVER_CONFIG_FIRST);
      rd(SRXC_ADDR_RECEIVER_CONFIG_SECOND, SRXC_RST_RECEIVER_CONFIG_SECOND);
      wr(7'h08, 8'hff);
      rd(7'h08, 8'hff);
      wr(7'h09, 8'hff);
      rd(7'h09, 8'hff);
      wr(7'h0a, 8'hff);
      rd(7'h0a, 8'hf3);
      wr(7'h0b, 8'h5a);
      rd(7'h0b, 8'h00);
      rd(7'h08, 8'hff);
      for (int i = 0; i < 4; i++) begin
         wr(7'h09, 8'(i << 5));
         wr(7'h0a, 8'h40 | 8'(i << 4));
         @(negedge clk_i);
         chk("ratio", i, recovered_clock_ratio_o);
         chk("ref_sel", i, pll_ref_port_select_o);
         chk("ref_port", 1, pll_ref_from_port_o);
      end
      wr(7'h0a, 8'h00);
      @(negedge clk_i);
      chk("ref_port", 0, pll_ref_from_port_o);
      wr(7'h09, 8'h80);
      @(negedge clk_i);
      chk("clk_sel", 0, rx_clk_internal_one_o);
      pll_locked_i = 0;
      repeat (2) @(negedge clk_i);
      chk("clk_sel", 1, rx_clk_internal_one_o);
      wr(7'h09, 8'h10);
      rx_cs_emphasis_i = 1;
      repeat (2) @(negedge clk_i);
      chk("clk_sel", 0, rx_clk_internal_one_o);
      chk("deemph", 1, deemphasis_active_o);
      pll_locked_i = 1;
      wr(7'h09, 8'h00);
      @(negedge clk_i);
      chk("deemph", 0, deemphasis_active_o);
      rx_cs_emphasis_i = 0;
      wr(7'h0a, 8'h80);
      rx(24'h123456, 5'h00, 0);
      chk("hard_mute", 0, last_rx);
      wr(7'h0a, 8'h00);
      rx(24'h123456, 5'h00, 3);
      chk("rx_pass", 24'h123456, last_rx);
      chk("src_in_data", 24'h123456, last_in);
      for (int m = 0; m < 4; m++) begin
         wr(7'h09, 8'(m << 2));
         rx(24'h111111, 5'h00, 0);
         rx(24'h222222, m[0] ? 5'h01 : 5'h02, 0);
         e = (m == 1) ? 24'h111111 : (m == 2) ? 24'h0 : 24'h222222;
         chk("err_mode", e, last_rx);
      end
      for (int m = 0; m < 4; m++) begin
         wr(7'h09, 8'(m));
         rx(24'h333333, 5'h00, 0);
         pll_locked_i = 0;
         rx(24'h444444, 5'h00, 0);
         e = (m == 1) ? 24'h333333 : (m == 2) ? 24'h0 : 24'h444444;
         if (m == 3) chk("lock_ramp", 1, last_rx != 0);
         else chk("lock_mode", e, last_rx);
         if (m == 3) for (int k = 0; k < 40; k++) rx(24'h444444, 5'h00, 0);
         if (m == 3) chk("lock_ramp", 0, last_rx);
         pll_locked_i = 1;
      end
      foreach (gate[i]) begin
         wr(7'h0a, {6'h00, gate[i][6:5]});
         n0 = n_in;
         rx(24'h0abcde, gate[i][4:0], 0);
         chk("src_in", gate[i][7], n_in - n0);
      end
      foreach (dly[i]) begin
         wr(7'h08, dly[i]);
         outq.delete();
         for (int k = 0; k <= dly[i] + 3; k++) sout(24'h1000 + k, k % 2);
         repeat (6) @(negedge clk_i);
         chk("delay", 24'h1003, outq[dly[i] + 3]);
      end
      for (int j = 1; j >= 0; j--) begin
         wr(7'h08, {j[0], 7'h00});
         outq.delete();
         for (int k = 0; k < 40; k++) sout(24'h010000, 0);
         repeat (6) @(negedge clk_i);
         if (j) chk("soft_start", 1, outq[1] != 0 && outq[1] < 24'h010000);
         chk("soft_mute", j ? 24'h0 : 24'h010000, outq[39]);
      end
      final_report();
   end
endmodule // srxc_top_tb
`default_nettype wire
